// >>> design/tmr8_defs.svh
// constants for the 8-bit timer with one compare channel
`ifndef TMR8_DEFS_SVH
`define TMR8_DEFS_SVH
`define TMR8_ADDR_CONTROL 12'h000
`define TMR8_ADDR_COUNT 12'h004
`define TMR8_ADDR_COMPARE 12'h008
`define TMR8_ADDR_FLAGS 12'h00c
`define TMR8_ADDR_MASK 12'h010
`define TMR8_ADDR_PORT 12'h014
`define TMR8_ADDR_SERVICE 12'h018
`define TMR8_BOTTOM 8'h00
`define TMR8_MAX 8'hff
`define TMR8_ONE 8'h01
// output action and clock source encodings
`define TMR8_ACT_NONE 2'h0
`define TMR8_ACT_TOGGLE 2'h1
`define TMR8_ACT_CLEAR 2'h2
`define TMR8_ACT_SET 2'h3
`define TMR8_CS_STOP 3'h0
// control register fields
`define TMR8_CTL_WAVE_LO 0
`define TMR8_CTL_ACT_LO 2
`define TMR8_CTL_CS_LO 4
`define TMR8_CTL_FORCE 7
// flag register fields
`define TMR8_FLG_OVF 0
`define TMR8_FLG_CMP 1
// mask register fields
`define TMR8_MSK_CMP 1
`define TMR8_MSK_GIE 2
`define TMR8_MSK_OVF 0
// port register fields
`define TMR8_PRT_DATA 0
`define TMR8_PRT_DIR 1
`endif

// >>> design/tmr8_pkg.sv
// types for the 8-bit timer with one compare channel
package tmr8_pkg;
    typedef enum logic [1:0] {
        TMR8_NORMAL = 2'h0,
        TMR8_PHASE_PWM = 2'h1,
        TMR8_CLEAR_ON_MATCH = 2'h2,
        TMR8_FAST_PWM = 2'h3
    } tmr8_wave_t;
    typedef struct packed {
        logic [2:0] clock_source_select;
        logic [1:0] output_action_bits;
        tmr8_wave_t waveform_select;
    } tmr8_ctl_t;
    typedef struct packed {
        logic compare_pin_direction;
        logic port_data;
    } tmr8_port_t;
endpackage : tmr8_pkg

// >>> design/tmr8_timer.sv
// 8-bit up/down timer counter with one output compare channel, apb slave
//
// Operation
// - each tick clears, increments or decrements counter
// - clock source zero means no ticks
// - counter readable and writable at any time
// - counter write beats tick update
// - comparator flags counter equal active compare
// - match sets flag on following tick
// - interrupt needs flag, enable, global enable
// - compare flag cleared by service or write-one; overflow by write-one
// - compare buffered in pwm modes only
// - buffer copied at top or bottom
// - compare access hits buffer or active register
// - force strobe acts as match outside pwm modes, no flag
// - counter write blocks next tick match
// - output register kept across mode changes
// - output action bits not buffered
// - reset clears compare output register
// - nonzero action bits override port data
// - override ignores waveform mode
// - action zero leaves output unchanged
// - bottom and top indications provided
// - bottom 0x00, max 0xff, top per mode
// - mode 0 counts up, overflow at wrap
// - mode 2 clears on match; 3,1 pwm
`timescale 1ns/1ps
`include "tmr8_defs.svh"
module tmr8_timer #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // tick from the prescaler, same clock domain
    input wire logic timer_tick,
    // interrupt service acknowledge from the core
    input wire logic compare_service_ack,
    // events and pin
    output logic compare_irq,
    output logic overflow_irq,
    output logic pin_out,
    output logic pin_oe
);
    tmr8_pkg::tmr8_ctl_t ctl;
    tmr8_pkg::tmr8_port_t port;
    logic [7:0] timer_count;
    logic [7:0] compare_value;
    logic [7:0] compare_buffer;
    logic compare_match_flag;
    logic overflow_flag;
    logic compare_interrupt_enable;
    logic overflow_interrupt_enable;
    logic global_enable;
    logic compare_output;
    logic count_down;
    logic block_match;
    logic [7:0] next_count;
    logic next_down;
    logic tick;
    logic is_pwm;
    logic at_bottom;
    logic at_top;
    logic match;
    logic wr;
    logic rd;
    logic hit_count;
    logic hit_control;
    logic hit_compare;
    logic hit_flags;
    logic hit_mask;
    logic hit_port;
    logic force_now;
    logic [31:0] next_rdata;
    logic next_err;
    logic wrap;
    logic [1:0] force_action;
    logic live_match;
    logic pwm_match_level;
    logic next_compare_output;

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;

    // address decode, one register per aligned word
    always_comb begin
        hit_control = 1'b0;
        hit_count = 1'b0;
        hit_compare = 1'b0;
        hit_flags = 1'b0;
        hit_mask = 1'b0;
        hit_port = 1'b0;
        if (paddr == ADDR_W'(`TMR8_ADDR_CONTROL)) begin
            hit_control = 1'b1;
        end else if (paddr == ADDR_W'(`TMR8_ADDR_COUNT)) begin
            hit_count = 1'b1;
        end else if (paddr == ADDR_W'(`TMR8_ADDR_COMPARE)) begin
            hit_compare = 1'b1;
        end else if (paddr == ADDR_W'(`TMR8_ADDR_FLAGS)) begin
            hit_flags = 1'b1;
        end else if (paddr == ADDR_W'(`TMR8_ADDR_MASK)) begin
            hit_mask = 1'b1;
        end else if (paddr == ADDR_W'(`TMR8_ADDR_PORT)) begin
            hit_port = 1'b1;
        end
    end

    assign tick = timer_tick && (ctl.clock_source_select != `TMR8_CS_STOP);
    assign is_pwm = ctl.waveform_select == tmr8_pkg::TMR8_PHASE_PWM
        || ctl.waveform_select == tmr8_pkg::TMR8_FAST_PWM;
    assign at_bottom = timer_count == `TMR8_BOTTOM;
    assign at_top = (ctl.waveform_select == tmr8_pkg::TMR8_CLEAR_ON_MATCH)
        ? match : (timer_count == `TMR8_MAX);
    assign match = timer_count == compare_value;
    assign force_now = wr && hit_control && pwdata[`TMR8_CTL_FORCE] && !is_pwm;

    // counting sequence per mode
    always_comb begin
        next_count = timer_count + `TMR8_ONE;
        next_down = count_down;
        wrap = 1'b0;
        case (ctl.waveform_select)
            tmr8_pkg::TMR8_NORMAL, tmr8_pkg::TMR8_FAST_PWM: begin
                wrap = timer_count == `TMR8_MAX;
            end
            tmr8_pkg::TMR8_CLEAR_ON_MATCH: begin
                if (match) begin
                    next_count = `TMR8_BOTTOM;
                end
                wrap = timer_count == `TMR8_MAX;
            end
            tmr8_pkg::TMR8_PHASE_PWM: begin
                if (count_down && at_bottom) begin
                    next_down = 1'b0;
                end else if (!count_down && timer_count == `TMR8_MAX) begin
                    next_down = 1'b1;
                end
                next_count = next_down ? timer_count - `TMR8_ONE
                    : timer_count + `TMR8_ONE;
                wrap = count_down && at_bottom;
            end
            default: begin
                wrap = 1'b0;
            end
        endcase
    end

    // counter: a bus write wins over any tick update
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_count <= `TMR8_BOTTOM;
        end else if (wr && hit_count) begin
            timer_count <= pwdata[7:0];
        end else if (tick) begin
            timer_count <= next_count;
        end
    end

    // count direction; only phase correct pwm ever turns down
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_down <= 1'b0;
        end else if (tick && !(wr && hit_count)) begin
            count_down <= next_down;
        end
    end

    // a counter write masks matches up to and including the next tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_match <= 1'b0;
        end else if (wr && hit_count) begin
            block_match <= 1'b1;
        end else if (tick) begin
            block_match <= 1'b0;
        end
    end

    // compare value: buffered in pwm modes, direct otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_value <= `TMR8_BOTTOM;
            compare_buffer <= `TMR8_BOTTOM;
        end else begin
            if (wr && hit_compare) begin
                compare_buffer <= pwdata[7:0];
            end
            if (wr && hit_compare && !is_pwm) begin
                compare_value <= pwdata[7:0];
            end else if (is_pwm && tick && (at_bottom || at_top)) begin
                compare_value <= compare_buffer;
            end
        end
    end

    // control; action bits take effect at once, never buffered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl <= '0;
            port <= '0;
            compare_interrupt_enable <= 1'b0;
            overflow_interrupt_enable <= 1'b0;
            global_enable <= 1'b0;
        end else begin
            if (wr && hit_control) begin
                ctl <= tmr8_pkg::tmr8_ctl_t'(pwdata[6:0]);
            end
            if (wr && hit_port) begin
                port <= tmr8_pkg::tmr8_port_t'(pwdata[1:0]);
            end
            if (wr && hit_mask) begin
                compare_interrupt_enable <= pwdata[`TMR8_MSK_CMP];
                overflow_interrupt_enable <= pwdata[`TMR8_MSK_OVF];
                global_enable <= pwdata[`TMR8_MSK_GIE];
            end
        end
    end

    // flags: hardware set beats software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_match_flag <= 1'b0;
            overflow_flag <= 1'b0;
        end else begin
            if (live_match) begin
                compare_match_flag <= 1'b1;
            end else if (compare_service_ack
                || (wr && hit_flags && pwdata[`TMR8_FLG_CMP])) begin
                compare_match_flag <= 1'b0;
            end
            if (tick && wrap && !(wr && hit_count)) begin
                overflow_flag <= 1'b1;
            end else if (wr && hit_flags && pwdata[`TMR8_FLG_OVF]) begin
                overflow_flag <= 1'b0;
            end
        end
    end

    // a control write with the strobe acts on the bits that it carries
    assign force_action = force_now ? pwdata[`TMR8_CTL_ACT_LO +: 2]
        : ctl.output_action_bits;
    assign live_match = tick && match && !block_match;
    // phase correct inverts the match level on the down slope
    assign pwm_match_level = (ctl.waveform_select == tmr8_pkg::TMR8_PHASE_PWM && count_down)
        ? !ctl.output_action_bits[0] : ctl.output_action_bits[0];

    // next value of the compare output register
    always_comb begin
        next_compare_output = compare_output;
        if (force_now || (live_match && !is_pwm)) begin
            case (force_action)
                `TMR8_ACT_TOGGLE: begin
                    next_compare_output = !compare_output;
                end
                `TMR8_ACT_CLEAR: begin
                    next_compare_output = 1'b0;
                end
                `TMR8_ACT_SET: begin
                    next_compare_output = 1'b1;
                end
                default: begin
                    next_compare_output = compare_output;
                end
            endcase
        end else if (tick && is_pwm && force_action[1]) begin
            // pwm: match level per slope, restored as fast pwm wraps
            if (live_match) begin
                next_compare_output = pwm_match_level;
            end else if (ctl.waveform_select == tmr8_pkg::TMR8_FAST_PWM && at_top) begin
                next_compare_output = !force_action[0];
            end
        end else if (live_match && force_action == `TMR8_ACT_TOGGLE
            && ctl.waveform_select == tmr8_pkg::TMR8_FAST_PWM) begin
            // toggle only in fast pwm; phase correct leaves the compare output unchanged
            next_compare_output = !compare_output;
        end
    end

    // compare output register, kept across mode changes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_output <= 1'b0;
        end else begin
            compare_output <= next_compare_output;
        end
    end

    // pin and interrupt outputs registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= 1'b0;
            pin_oe <= 1'b0;
            compare_irq <= 1'b0;
            overflow_irq <= 1'b0;
        end else begin
            pin_out <= (ctl.output_action_bits != `TMR8_ACT_NONE) ? compare_output
                : port.port_data;
            pin_oe <= port.compare_pin_direction;
            compare_irq <= compare_match_flag && compare_interrupt_enable
                && global_enable;
            overflow_irq <= overflow_flag && overflow_interrupt_enable && global_enable;
        end
    end

    // read mux
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        if (hit_control) begin
            next_rdata = {25'h0, ctl};
        end else if (hit_count) begin
            next_rdata = {24'h0, timer_count};
        end else if (hit_compare) begin
            next_rdata = {24'h0, is_pwm ? compare_buffer : compare_value};
        end else if (hit_flags) begin
            next_rdata = {30'h0, compare_match_flag, overflow_flag};
        end else if (hit_mask) begin
            next_rdata = {29'h0, global_enable, compare_interrupt_enable,
                overflow_interrupt_enable};
        end else if (hit_port) begin
            next_rdata = {29'h0, compare_output, port};
        end else begin
            next_err = 1'b1;
        end
    end

    // apb answer: zero wait, pready and data registered in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && next_err;
            prdata <= (psel && !penable && !pwrite) ? next_rdata : 32'h0000_0000;
        end
    end
endmodule : tmr8_timer

// >>> bench/tmr8_timer_chk.sv
// port checker for the 8-bit timer, bound to the design top
`timescale 1ns/1ps
`include "tmr8_defs.svh"
module tmr8_chk #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // events and pin
    input wire logic timer_tick,
    input wire logic compare_service_ack,
    input wire logic compare_irq,
    input wire logic overflow_irq,
    input wire logic pin_out,
    input wire logic pin_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_done;
    assign wr_done = psel && penable && pready && pwrite;
    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    property p_idle; !psel |=> !pready && prdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_err; psel && !penable && paddr == `TMR8_ADDR_SERVICE |=> pslverr; endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_oe_on; wr_done && paddr == `TMR8_ADDR_PORT && pwdata[1] |=> ##1 pin_oe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("pin not driven");
    property p_oe_off; wr_done && paddr == `TMR8_ADDR_PORT && !pwdata[1] |=> ##1 !pin_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("pin driven as input");
    property p_mask; wr_done && paddr == `TMR8_ADDR_MASK && !(pwdata[1] && pwdata[2])
        |=> ##1 !compare_irq; endproperty
    a_mask: assert property (p_mask) else $error("masked compare irq");
    property p_svc; compare_service_ack && !timer_tick |=> ##1 !compare_irq; endproperty
    a_svc: assert property (p_svc) else $error("service left irq up");
    property p_w1c; wr_done && paddr == `TMR8_ADDR_FLAGS && pwdata[1] && !timer_tick
        |=> ##1 !compare_irq; endproperty
    a_w1c: assert property (p_w1c) else $error("write one left irq up");
    property p_rst; $rose(presetn) |-> !pin_out && !pin_oe && !compare_irq; endproperty
    a_rst: assert property (p_rst) else $error("outputs not clear after reset");
endmodule : tmr8_chk
bind tmr8_timer tmr8_chk #(.ADDR_W(ADDR_W)) tmr8_chk_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_tick(timer_tick),
    .compare_service_ack(compare_service_ack), .compare_irq(compare_irq),
    .overflow_irq(overflow_irq), .pin_out(pin_out), .pin_oe(pin_oe));

// >>> bench/tmr8_core_model.sv
// core model that services the compare interrupt
`timescale 1ns/1ps
module tmr8_core_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // service handshake
    input wire logic svc_en,
    input wire logic compare_irq,
    output logic compare_service_ack
);
    logic busy;
    // busy hides the irq level that lags the flag by a cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_service_ack <= 1'b0;
            busy <= 1'b0;
        end else begin
            compare_service_ack <= svc_en && compare_irq && !compare_service_ack && !busy;
            busy <= compare_service_ack;
        end
    end
endmodule : tmr8_core_model

// >>> bench/tmr8_tb_top.sv
// self-checking bench for the 8-bit timer
`timescale 1ns/1ps
`include "tmr8_defs.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, timer_tick, svc_en, ack;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic pready, pslverr, compare_irq, overflow_irq, pin_out, pin_oe;
    int errors = 0;
    int cmp_count = 0;
    tmr8_timer tmr8_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timer_tick(timer_tick),
        .compare_service_ack(ack), .compare_irq(compare_irq), .overflow_irq(overflow_irq),
        .pin_out(pin_out), .pin_oe(pin_oe));
    tmr8_core_model tmr8_core_model_inst (.pclk(pclk), .presetn(presetn), .svc_en(svc_en),
        .compare_irq(compare_irq), .compare_service_ack(ack));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n == 16) errors++;
        rdata = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rdata, e)
    endtask : rd
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge pclk);
            timer_tick <= 1'b1;
            @(posedge pclk);
            timer_tick <= 1'b0;
        end
    endtask : tick
    // pins are registered, so wait one edge past the write
    task automatic settle();
        @(posedge pclk);
        @(negedge pclk);
    endtask : settle
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (3000) @(posedge pclk);
        errors++;
        end_of_test();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        timer_tick = 1'b0;
        svc_en = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) rd(12'(4 * i), 32'h0);
        $display("test reset done");
        wr(`TMR8_ADDR_COUNT, 32'h10);
        tick(3);
        rd(`TMR8_ADDR_COUNT, 32'h10);
        wr(`TMR8_ADDR_CONTROL, 32'h10);
        wr(`TMR8_ADDR_COUNT, 32'hfe);
        tick(2);
        rd(`TMR8_ADDR_COUNT, 32'h0);
        rd(`TMR8_ADDR_FLAGS, 32'h1);
        fork
            wr(`TMR8_ADDR_COUNT, 32'h33);
            tick(1);
        join
        rd(`TMR8_ADDR_COUNT, 32'h33);
        $display("test count done");
        wr(`TMR8_ADDR_COMPARE, 32'h5);
        wr(`TMR8_ADDR_MASK, 32'h7);
        settle();
        `CHK(overflow_irq, 1'b1)
        wr(`TMR8_ADDR_FLAGS, 32'h3);
        settle();
        `CHK(overflow_irq, 1'b0)
        wr(`TMR8_ADDR_COUNT, 32'h5);
        tick(1);
        rd(`TMR8_ADDR_FLAGS, 32'h0);
        wr(`TMR8_ADDR_COUNT, 32'h4);
        tick(2);
        rd(`TMR8_ADDR_FLAGS, 32'h2);
        `CHK(compare_irq, 1'b1)
        rd(`TMR8_ADDR_PORT, 32'h0);
        wr(`TMR8_ADDR_FLAGS, 32'h0);
        rd(`TMR8_ADDR_FLAGS, 32'h2);
        svc_en <= 1'b1;
        repeat (5) @(posedge pclk);
        `CHK(compare_irq, 1'b0)
        rd(`TMR8_ADDR_FLAGS, 32'h0);
        svc_en <= 1'b0;
        wr(`TMR8_ADDR_MASK, 32'h4);
        $display("test compare done");
        wr(`TMR8_ADDR_CONTROL, 32'h84);
        rd(`TMR8_ADDR_PORT, 32'h4);
        rd(`TMR8_ADDR_FLAGS, 32'h0);
        rd(`TMR8_ADDR_COUNT, 32'h6);
        wr(`TMR8_ADDR_PORT, 32'h2);
        settle();
        `CHK({pin_oe, pin_out}, 2'b11)
        wr(`TMR8_ADDR_CONTROL, 32'h3);
        settle();
        `CHK(pin_out, 1'b0)
        rd(`TMR8_ADDR_PORT, 32'h6);
        wr(`TMR8_ADDR_CONTROL, 32'h7);
        settle();
        `CHK(pin_out, 1'b1)
        wr(`TMR8_ADDR_PORT, 32'h1);
        settle();
        `CHK({pin_oe, pin_out}, 2'b01)
        $display("test pin done");
        wr(`TMR8_ADDR_COMPARE, 32'h20);
        rd(`TMR8_ADDR_COMPARE, 32'h20);
        wr(`TMR8_ADDR_CONTROL, 32'h0);
        rd(`TMR8_ADDR_COMPARE, 32'h5);
        wr(`TMR8_ADDR_CONTROL, 32'h13);
        wr(`TMR8_ADDR_COUNT, 32'hff);
        tick(1);
        wr(`TMR8_ADDR_CONTROL, 32'h0);
        rd(`TMR8_ADDR_COMPARE, 32'h20);
        $display("test buffer done");
        end_of_test();
    end
endmodule : tb_top
